// ### hw/cfg_port_cfg.svh
// Constants for the configuration index/data port block
//
// Contract
// [RQ1] Index register is the 32-bit I/O port at 16'h0cf8, selects the target.
// [RQ2] Data register at 16'h0cfc reads or writes the currently selected register.
// [RQ3] Index bit 31 enables routing of data accesses as configuration accesses.
// [RQ4] Bus field starts at bit 16, device at 11, function at 8.
// [RQ5] Bits 7:2 pick the dword register; bits 1:0 and 30:24 ignored.
// [RQ6] Requester writes index with 32 bits, then reads 32-bit data.
// [RQ7] Nodes answer on bus 0, devices 18h to 1Fh, function 0.
// [RQ8] Up to eight nodes, one configuration device per node.
// [RQ9] Link status reports connected in bit 0, noncoherent in bit 2.
// [RQ10] Link status registers at function 0 offsets 98h, B8h, D8h, F8h.
// [RQ11] Link status bits are read-only; writes are ignored.
// [RQ12] Requester keeps exclusive use of the index/data port pair.
`ifndef CFG_PORT_CFG_SVH
`define CFG_PORT_CFG_SVH

// ****************************************
// Port addresses
// ****************************************
`define IO_INDEX_PORT     16'h0cf8
`define IO_DATA_PORT      16'h0cfc

// ****************************************
// Index field positions
// ****************************************
`define IDX_ENABLE_BIT    31
`define IDX_BUS_LSB       16
`define IDX_DEV_LSB       11
`define IDX_FUNC_LSB      8
`define IDX_REG_LSB       2
`define IDX_RESET         32'h0000_0000
`define IDX_WRITABLE_MASK 32'h80ff_fffc

// ****************************************
// Node range and link registers
// ****************************************
`define NODE_COUNT        8
`define NODE_DEV_BASE     5'h18
`define NODE_BUS          8'h00
`define NODE_FUNC         3'h0
`define LINK_COUNT        4
`define LINK0_REG_OFFSET  8'h98
`define LINK1_REG_OFFSET  8'hb8
`define LINK2_REG_OFFSET  8'hd8
`define LINK3_REG_OFFSET  8'hf8
`define LINK_ATTACHED_BIT 0
`define LINK_INIT_BIT     1
`define LINK_NONCOH_BIT   2
`define LINK_PEND_BIT     4
`define NO_TARGET_DATA    32'hffff_ffff

`endif

// ### hw/cfg_port_pkg.sv
// Types shared by the configuration port block
`default_nettype none
package cfg_port_pkg;
  // One processor I/O cycle
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] port;
    logic [31:0] wdata;
  } io_req_t;

  // Answer to an I/O cycle
  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } io_rsp_t;

  // Link state flags for one link
  typedef struct packed {
    logic pending;
    logic noncoherent;
    logic init_done;
    logic attached;
  } link_state_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RESPOND} port_state_t;
endpackage
`default_nettype wire

// ### hw/config_space_access_port.sv
// Host-bridge index/data configuration port with per-node link status
`include "cfg_port_cfg.svh"
`default_nettype none
module config_space_access_port (
  input  wire logic                                  clk_sys,
  input  wire logic                                  nrst,
  input  wire logic [2:0]                            node_id,
  input  wire logic [`NODE_COUNT-1:0]                node_present,
  input  wire cfg_port_pkg::link_state_t [`LINK_COUNT-1:0] link_state,
  input  wire cfg_port_pkg::io_req_t                 io_req,
  output var  cfg_port_pkg::io_rsp_t                 io_rsp,
  output var  logic [31:0]                           index_out
);

  // ****************************************
  // Decode helpers
  // ****************************************
  // Link number for a dword offset, or 3'h4 when no link register lives there
  function automatic logic [2:0] link_of(input logic [7:0] off);
    if (off == `LINK0_REG_OFFSET) begin
      link_of = 3'h0;
    end else if (off == `LINK1_REG_OFFSET) begin
      link_of = 3'h1;
    end else if (off == `LINK2_REG_OFFSET) begin
      link_of = 3'h2;
    end else if (off == `LINK3_REG_OFFSET) begin
      link_of = 3'h3;
    end else begin
      link_of = 3'h4;
    end
  endfunction

  // Status word for one link; upper bits read as zero
  function automatic logic [31:0] link_word(input cfg_port_pkg::link_state_t s);
    link_word                      = 32'h0000_0000;
    link_word[`LINK_ATTACHED_BIT]  = s.attached;
    link_word[`LINK_INIT_BIT]      = s.init_done;
    link_word[`LINK_NONCOH_BIT]    = s.noncoherent;
    link_word[`LINK_PEND_BIT]      = s.pending;
  endfunction

  // Index port write; the capture path and its hold check share this decode
  function automatic logic is_index_write(input cfg_port_pkg::io_req_t r);
    is_index_write = r.valid && r.write && (r.port == `IO_INDEX_PORT);
  endfunction

  // Top device bits shared by every node in the bus 0 range
  localparam logic [4:0] node_dev_base = `NODE_DEV_BASE;

  logic [31:0]              index_reg;
  logic [31:0]              index_next;
  cfg_port_pkg::port_state_t state_reg;
  cfg_port_pkg::io_rsp_t    rsp_reg;
  logic [31:0]              rd_word;
  logic                     hits_node;
  logic [7:0]               sel_bus;
  logic [4:0]               sel_dev;
  logic [2:0]               sel_func;
  logic [7:0]               sel_off;
  logic [2:0]               sel_node;
  logic [2:0]               sel_link;
  logic [31:0]              link_words [`LINK_COUNT];

  // Field extraction by shifting, reserved bits dropped
  assign sel_bus  = index_reg[`IDX_BUS_LSB +: 8];             // RQ4
  assign sel_dev  = index_reg[`IDX_DEV_LSB +: 5];             // RQ4
  assign sel_func = index_reg[`IDX_FUNC_LSB +: 3];            // RQ4
  assign sel_off  = {index_reg[7:`IDX_REG_LSB], 2'b00};       // RQ5
  assign sel_node = sel_dev[2:0];
  assign sel_link = link_of(sel_off);

  // Link words built per link
  genvar gi;
  generate
    for (gi = 0; gi < `LINK_COUNT; gi++) begin : g_link
      assign link_words[gi] = link_word(link_state[gi]);      // RQ9
    end
  endgenerate

  // ****************************************
  // Target match
  // ****************************************
  // Only this node's own device in 18h..1Fh answers; others are left to their owners
  always_comb begin
    hits_node = index_reg[`IDX_ENABLE_BIT]                    // RQ3
             && (sel_bus == `NODE_BUS)                        // RQ7
             && (sel_dev[4:3] == node_dev_base[4:3])          // RQ7
             && (sel_func == `NODE_FUNC)                      // RQ7
             && (sel_node == node_id)                         // RQ8
             && node_present[sel_node];                       // RQ8
  end

  // Read mux; link registers, zero for other offsets of this node, all else floats high like an absent device
  always_comb begin
    rd_word = `NO_TARGET_DATA;
    if (hits_node && sel_link != 3'h4) begin
      rd_word = link_words[sel_link[1:0]];                    // RQ10
    end else if (hits_node) begin
      rd_word = 32'h0000_0000;
    end
  end

  // ****************************************
  // Index register
  // ****************************************
  // Reserved bits are kept at zero so a readback shows only live fields
  always_comb begin
    index_next = index_reg;
    if (is_index_write(io_req)) begin
      index_next = io_req.wdata & `IDX_WRITABLE_MASK;         // RQ1 RQ5
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      index_reg <= `IDX_RESET;
    end else begin
      index_reg <= index_next;
    end
  end

  // ****************************************
  // Answer path
  // ****************************************
  // Every cycle taken in ST_IDLE gets a one-cycle answer so software never hangs on a bad port
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= cfg_port_pkg::ST_IDLE;
      rsp_reg   <= '0;
    end else begin
      case (state_reg)
        cfg_port_pkg::ST_IDLE: begin
          rsp_reg <= '0;
          if (io_req.valid) begin
            state_reg     <= cfg_port_pkg::ST_RESPOND;
            rsp_reg.valid <= 1'b1;
            if (io_req.write) begin
              rsp_reg.rdata <= 32'h0000_0000;                 // RQ11
            end else if (io_req.port == `IO_INDEX_PORT) begin
              rsp_reg.rdata <= index_reg;                     // RQ1
            end else if (io_req.port == `IO_DATA_PORT) begin
              rsp_reg.rdata <= rd_word;                       // RQ2 RQ6
            end else begin
              rsp_reg.rdata <= `NO_TARGET_DATA;
            end
          end
        end
        cfg_port_pkg::ST_RESPOND: begin
          // Answer slot: a cycle arriving now is dropped, only the index path sees it
          state_reg <= cfg_port_pkg::ST_IDLE;
          rsp_reg   <= '0;
        end
        default: begin
          state_reg <= cfg_port_pkg::ST_IDLE;
          rsp_reg   <= '0;
        end
      endcase
    end
  end

  // Both outputs come straight from their flops
  assign io_rsp    = rsp_reg;
  assign index_out = index_reg;

  // ****************************************
  // Checks on the index register
  // ****************************************
  // Index port writes land with the reserved bits dropped
  chk_index_write: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ1
    io_req.valid && io_req.write && io_req.port == `IO_INDEX_PORT
      |=> index_reg == ($past(io_req.wdata) & `IDX_WRITABLE_MASK))
    else $error("index port write not captured");

  // Nothing but an index port write may move the selector
  chk_index_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ1
    !is_index_write(io_req) |=> $stable(index_reg))
    else $error("index changed without an index write");

  // Fields sit where software shifts them in
  chk_field_shift: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ4
    sel_dev == index_reg[15:11] && sel_func == index_reg[10:8] && sel_bus == index_reg[23:16])
    else $error("index fields misplaced");

  // Reserved bits never reach the stored selector
  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ5
    index_reg[30:24] == 7'h00 && index_reg[1:0] == 2'b00)
    else $error("reserved index bits stored");

  // ****************************************
  // Checks on the answer path
  // ****************************************
  // Index read returns the selector as it stood when asked
  chk_index_read: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ1
    state_reg == cfg_port_pkg::ST_IDLE && io_req.valid && !io_req.write && io_req.port == `IO_INDEX_PORT
      |=> io_rsp.valid && io_rsp.rdata == $past(index_reg))
    else $error("index port read returned wrong word");

  // Data read carries the routed word
  chk_data_read: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ2
    state_reg == cfg_port_pkg::ST_IDLE && io_req.valid && !io_req.write && io_req.port == `IO_DATA_PORT
      |=> io_rsp.valid && io_rsp.rdata == $past(rd_word))
    else $error("data port read returned wrong word");

  // Writes are answered with zero data
  chk_write_answer: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ11
    state_reg == cfg_port_pkg::ST_IDLE && io_req.valid && io_req.write
      |=> io_rsp.valid && io_rsp.rdata == 32'h0000_0000)
    else $error("write answered with data");

  // Ports outside the pair read as an absent device
  chk_unmapped_port: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ2
    state_reg == cfg_port_pkg::ST_IDLE && io_req.valid && !io_req.write
      && io_req.port != `IO_INDEX_PORT && io_req.port != `IO_DATA_PORT
      |=> io_rsp.valid && io_rsp.rdata == `NO_TARGET_DATA)
    else $error("unmapped port answered with data");

  // One answer per accepted cycle, one cycle long
  chk_single_answer: assert property (@(posedge clk_sys) disable iff (!nrst)
    io_rsp.valid |=> !io_rsp.valid)
    else $error("answer held longer than one cycle");

  // A cycle in the answer slot is dropped without an answer
  chk_refused_slot: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg == cfg_port_pkg::ST_RESPOND && io_req.valid |=> !io_rsp.valid)
    else $error("cycle in answer slot was answered");

  // No answer appears unless a cycle was taken
  chk_idle_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg == cfg_port_pkg::ST_IDLE && !io_req.valid |=> !io_rsp.valid)
    else $error("answer without a cycle");

  // An answer only ever stands in the answer slot
  chk_answer_state: assert property (@(posedge clk_sys) disable iff (!nrst)
    io_rsp.valid |-> state_reg == cfg_port_pkg::ST_RESPOND)
    else $error("answer outside the answer slot");

  // ****************************************
  // Checks on routing
  // ****************************************
  // A clear enable bit leaves every target silent
  chk_enable_gate: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ3
    !index_reg[`IDX_ENABLE_BIT] |-> rd_word == `NO_TARGET_DATA)
    else $error("disabled index still routed");

  // Only bus 0, function 0, upper device range
  chk_node_range: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ7
    hits_node |-> sel_dev >= 5'h18 && sel_bus == 8'h00 && sel_func == 3'h0)
    else $error("node answered outside range");

  // This node answers for its own device number only
  chk_one_device: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ8
    hits_node |-> sel_dev == {2'b11, node_id})
    else $error("node answered for another device");

  // Another node's device reads as absent here
  chk_foreign_device: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ8
    sel_dev[2:0] != node_id |-> rd_word == `NO_TARGET_DATA)
    else $error("foreign device routed here");

  // An absent node never answers
  chk_absent_node: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ8
    !node_present[node_id] |-> rd_word == `NO_TARGET_DATA)
    else $error("absent node answered");

  // ****************************************
  // Checks on link status
  // ****************************************
  // Connected and noncoherent bits of link 0
  chk_link_bits: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ9
    hits_node && sel_off == 8'h98 |-> rd_word[0] == link_state[0].attached
      && rd_word[2] == link_state[0].noncoherent)
    else $error("link status bits wrong");

  // Link 1 word, built from the flags directly
  chk_link_one: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ10
    hits_node && sel_off == 8'hb8 |-> rd_word == {27'h0, link_state[1].pending, 1'h0,
      link_state[1].noncoherent, link_state[1].init_done, link_state[1].attached})
    else $error("link 1 status not at b8");

  // Link 2 word, built from the flags directly
  chk_link_two: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ10
    hits_node && sel_off == 8'hd8 |-> rd_word == {27'h0, link_state[2].pending, 1'h0,
      link_state[2].noncoherent, link_state[2].init_done, link_state[2].attached})
    else $error("link 2 status not at d8");

  // Link 3 word at the last offset
  chk_link_offset: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ10
    hits_node && sel_off == 8'hf8 |-> rd_word == link_words[3])
    else $error("link 3 status not at f8");

  // Other offsets of this node read as zero
  chk_non_link_zero: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ10
    hits_node && sel_off != 8'h98 && sel_off != 8'hb8 && sel_off != 8'hd8 && sel_off != 8'hf8
      |-> rd_word == 32'h0000_0000)
    else $error("non-link offset returned data");

  // A data write leaves the status word as the flags say
  chk_write_ignored: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ11
    io_req.valid && io_req.write && io_req.port == `IO_DATA_PORT ##1 hits_node && sel_off == 8'h98
      |-> rd_word == link_words[0])
    else $error("link status changed by write");

endmodule
`default_nettype wire

// ### verif/io_requester.sv
// Processor-side model issuing whole 32-bit I/O cycles
`default_nettype none
module io_requester (
  input  wire cfg_port_pkg::io_rsp_t io_rsp,
  input  wire logic                  clk_sys,
  output var  cfg_port_pkg::io_req_t io_req
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Bus cycle
  // ****************************************
  initial io_req = '0;

  // One cycle at a time, never overlapped, so the port pair stays ours
  task automatic cycle(input logic w, input logic [15:0] p, input logic [31:0] d,
                       output logic [31:0] q, output logic ok);
    @(posedge clk_sys);
    io_req <= {1'b1, w, p, d};
    @(posedge clk_sys);
    // Released lines flip so stale values never look like a request
    io_req <= {1'b0, ~w, ~p, ~d};
    @(posedge clk_sys);
    ok = io_rsp.valid;
    q = io_rsp.rdata;
  endtask

  // Second cycle lands in the answer slot of a read; it must go unanswered
  task automatic pair(input logic [15:0] p, input logic [31:0] d,
                      output logic [31:0] q, output logic ok, output logic extra);
    @(posedge clk_sys);
    io_req <= {1'b1, 1'b0, p, 32'h0000_0000};
    @(posedge clk_sys);
    io_req <= {1'b1, 1'b1, p, d};
    @(posedge clk_sys);
    io_req <= {1'b0, 1'b0, ~p, ~d};
    ok = io_rsp.valid;
    q = io_rsp.rdata;
    @(posedge clk_sys);
    extra = io_rsp.valid;
  endtask
endmodule
`default_nettype wire

// ### verif/config_space_access_port_bench.sv
// Self-checking bench for the configuration index/data port
`include "cfg_port_cfg.svh"
`default_nettype none
module config_space_access_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                            clk_sys = 1'b0;
  logic                            nrst = 1'b0;
  logic [2:0]                      node_id = 3'h3;
  logic [7:0]                      node_present = 8'h0f;
  cfg_port_pkg::link_state_t [3:0] link_state = 16'hf365;
  cfg_port_pkg::io_req_t           io_req;
  cfg_port_pkg::io_rsp_t           io_rsp;
  logic [31:0]                     index_out;
  logic [31:0]                     idx_row [10];
  logic [31:0]                     exp_row [10];
  logic [31:0]                     q;
  logic                            pair_ok;
  logic                            pair_extra;
  int                              n_fail = 0;
  int                              checks_done = 0;

  config_space_access_port u_config_space_access_port (.clk_sys(clk_sys), .nrst(nrst), .node_id(node_id),
    .node_present(node_present), .link_state(link_state), .io_req(io_req), .io_rsp(io_rsp), .index_out(index_out));
  io_requester u_io_requester (.io_rsp(io_rsp), .clk_sys(clk_sys), .io_req(io_req));

  // ****************************************
  // Helpers
  // ****************************************
  // 100 ns period
  always #50 clk_sys = ~clk_sys;

  function automatic logic [31:0] sel(logic en, logic [7:0] b, logic [4:0] dv, logic [2:0] f, logic [7:0] r);
    return {en, 7'h00, b, dv, f, r};
  endfunction

  // Link word worked out from the live flags
  function automatic logic [31:0] lw(int l);
    return {27'h0, link_state[l].pending, 1'b0, link_state[l].noncoherent,
            link_state[l].init_done, link_state[l].attached};
  endfunction

  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", what, e, g);
      n_fail++;
    end
  endtask

  task automatic io(input logic w, input logic [15:0] p, input logic [31:0] d, output logic [31:0] r);
    logic ok;
    u_io_requester.cycle(w, p, d, r, ok);
    chk("answer valid", 32'h1, {31'h0, ok});
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  // Row table first, then reset and corner cases
  initial begin
    for (int i = 0; i < 4; i++) begin
      idx_row[i] = sel(1'b1, 8'h00, 5'h1b, 3'h0, 8'h98 + 8'h20 * i[7:0]);
      exp_row[i] = lw(i);
    end
    idx_row[4] = sel(1'b0, 8'h00, 5'h1b, 3'h0, 8'h98);
    idx_row[5] = sel(1'b1, 8'h01, 5'h1b, 3'h0, 8'h98);
    idx_row[6] = sel(1'b1, 8'h00, 5'h1a, 3'h0, 8'h98);
    idx_row[7] = sel(1'b1, 8'h00, 5'h1b, 3'h1, 8'h98);
    idx_row[8] = sel(1'b1, 8'h00, 5'h1b, 3'h0, 8'h60);
    idx_row[9] = idx_row[0] | 32'h7f00_0003;
    for (int i = 4; i < 8; i++) begin
      exp_row[i] = 32'hffff_ffff;
    end
    exp_row[8] = 32'h0;
    exp_row[9] = lw(0);
    repeat (6) @(posedge clk_sys);
    chk("index_out at reset", 32'h0, index_out);
    nrst <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      io(1'b1, `IO_INDEX_PORT, idx_row[i], q);
      chk("index_out", idx_row[i] & `IDX_WRITABLE_MASK, index_out);
      io(1'b0, `IO_INDEX_PORT, 32'h0, q);
      chk("index read", idx_row[i] & `IDX_WRITABLE_MASK, q);
      io(1'b0, `IO_DATA_PORT, 32'h0, q);
      chk("data read", exp_row[i], q);
    end
    // Writing a status word must leave it untouched
    io(1'b1, `IO_DATA_PORT, 32'hffff_ffff, q);
    chk("data write answer", 32'h0, q);
    io(1'b0, `IO_DATA_PORT, 32'h0, q);
    chk("after write", lw(0), q);
    io(1'b0, 16'h0cf0, 32'h0, q);
    chk("unmapped port", 32'hffff_ffff, q);
    // Top of the node range, with flags changed live
    @(posedge clk_sys);
    node_id <= 3'h7;
    node_present <= 8'h80;
    link_state <= 16'h9fff;
    io(1'b1, `IO_INDEX_PORT, sel(1'b1, 8'h00, 5'h1f, 3'h0, 8'hf8), q);
    io(1'b0, `IO_DATA_PORT, 32'h0, q);
    chk("node 7 link 3", lw(3), q);
    node_present <= 8'h7f;
    io(1'b0, `IO_DATA_PORT, 32'h0, q);
    chk("absent node", 32'hffff_ffff, q);
    // A cycle in the answer slot goes unanswered, yet the index path still takes it
    u_io_requester.pair(`IO_INDEX_PORT, idx_row[2], q, pair_ok, pair_extra);
    chk("pair first answer", sel(1'b1, 8'h00, 5'h1f, 3'h0, 8'hf8), q);
    chk("pair first valid", 32'h1, {31'h0, pair_ok});
    chk("pair second valid", 32'h0, {31'h0, pair_extra});
    chk("pair index", idx_row[2] & `IDX_WRITABLE_MASK, index_out);
    // Second reset in mid-run clears the selector
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("index_out in reset", 32'h0, index_out);
    chk("answer in reset", 32'h0, io_rsp.rdata);
    nrst <= 1'b1;
    io(1'b0, `IO_INDEX_PORT, 32'h0, q);
    chk("index after reset", 32'h0, q);
    end_sim;
  end

  // Run needs about 125 cycles; a hang ends here
  initial begin
    repeat (2000) @(posedge clk_sys);
    n_fail++;
    $display("BAD watchdog exp %h got %h", 32'h0, 32'h1);
    end_sim;
  end
endmodule
`default_nettype wire
